//--- core/clock_power_ctrl.sv
// Function
// - Any block that has no work has its clock enable dropped so it does not toggle.
// - A gated block has its clock enable back on the cycle right after work is dispatched.
// - Core frequency changes only when software writes the core config register.
// - Each core can take its clock directly from one of two PLLs.
// - Each core can instead take an integer-divided clock from two of the three PLLs.
// - A change of source or divider completes within a few source edges and never glitches.
// - Software can write the block disable register to switch off clocks of unused blocks.
// - A disabled block stays off until chip reset; writing zero does not bring it back.
// - The core divider offers at least divide-by-two and divide-by-four.
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module clock_power_ctrl
    import clk_ctrl_pkg::*;
#(
    parameter int NCORE = 4,
    parameter int NBLK = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire axiReq_t axiReq,
    output axiRsp_t axiRsp,
    input wire logic [NUM_PLLS-1:0] pllLevel,
    input wire logic [NBLK-1:0] workDispatch,
    input wire logic [NBLK-1:0] blockBusy,
    output logic [NBLK-1:0] blockClkEn,
    output logic [NCORE-1:0] coreClk,
    output logic [NCORE-1:0] coreSwitching
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    generate
        if (NCORE < 1 || NCORE > MAX_CORES) begin : g_badCore
            $error("NCORE must be 1 to 8");
        end
        if (NBLK < 1 || NBLK > MAX_BLKS) begin : g_badBlk
            $error("NBLK must be 1 to 32");
        end
        if (NUM_PLLS != 3) begin : g_badPll
            $error("Core switch taps need exactly three PLLs");
        end
        if (NCORE * CFG_NIB_W > 32) begin : g_badCfg
            $error("Core config nibbles must fit one word");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic awFull;
        logic [ADDR_W-1:0] awAddr;
        logic wFull;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic awRdy;
        logic wRdy;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [31:0] coreCfg;
        logic [31:0] blkDis;
        logic [NBLK-1:0] blkEn;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;

    logic [NCORE-1:0] swBusy;
    logic [NCORE-1:0] coreClkW;

    ////////////////////////////////////////////////////////////////////////////
    // Masks of implemented bits
    function automatic logic [31:0] cfgMask();
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < NCORE; i++) begin
            m[i*CFG_NIB_W +: CFG_NIB_W] = CFG_NIB_MASK;
        end
        return m;
    endfunction : cfgMask

    function automatic logic [31:0] blkMask();
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < NBLK; i++) begin
            m[i] = 1'b1;
        end
        return m;
    endfunction : blkMask

    localparam logic [31:0] CFG_MASK = cfgMask();
    localparam logic [31:0] BLK_MASK = blkMask();

    ////////////////////////////////////////////////////////////////////////////
    // Decode, shared by read and write paths
    function automatic regSel_t decode(input logic [ADDR_W-1:0] a);
        regSel_t r;
        case (a)
            OFF_CORE_CFG: r = SEL_CORE_CFG;
            OFF_CORE_STAT: r = SEL_CORE_STAT;
            OFF_BLK_DIS: r = SEL_BLK_DIS;
            OFF_BLK_EN: r = SEL_BLK_EN;
            default: r = SEL_NONE;
        endcase
        return r;
    endfunction : decode

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] st
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [31:0] pad(input logic [NBLK-1:0] v);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[NBLK-1:0] = v;
        return r;
    endfunction : pad

    function automatic logic [31:0] padCore(input logic [NCORE-1:0] v);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[NCORE-1:0] = v;
        return r;
    endfunction : padCore

    // Byte lanes selected by the write strobes
    function automatic logic [31:0] strobeMask(input logic [3:0] st);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{st[b]}};
        end
        return m;
    endfunction : strobeMask

    // Unmapped write answers an error; read-only targets just drop the data
    function automatic logic [1:0] writeResp(input regSel_t sel);
        logic [1:0] r;
        case (sel)
            SEL_NONE: r = RESP_SLVERR;
            default: r = RESP_OKAY;
        endcase
        return r;
    endfunction : writeResp

    // Read mux, response code above the data word
    function automatic logic [33:0] readMux(
        input regSel_t sel,
        input logic [31:0] cfg,
        input logic [31:0] dis,
        input logic [NBLK-1:0] en,
        input logic [NCORE-1:0] busy
    );
        logic [33:0] r;
        case (sel)
            SEL_CORE_CFG: r = {RESP_OKAY, cfg};
            SEL_CORE_STAT: r = {RESP_OKAY, padCore(busy)};
            SEL_BLK_DIS: r = {RESP_OKAY, dis};
            SEL_BLK_EN: r = {RESP_OKAY, pad(en)};
            default: r = {RESP_SLVERR, 32'h0000_0000};
        endcase
        return r;
    endfunction : readMux

    // Config nibble of one core, reserved top bit dropped
    function automatic coreCfg_t coreReq(input logic [31:0] cfg, input int c);
        return coreCfg_t'(cfg[c*CFG_NIB_W +: CFG_USED_W]);
    endfunction : coreReq

    ////////////////////////////////////////////////////////////////////////////
    // Per-block demand: dispatch this cycle or work still pending
    logic [NBLK-1:0] demand;

    generate
        for (genvar b = 0; b < NBLK; b++) begin : g_blk
            assign demand[b] = workDispatch[b] | blockBusy[b];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        regSel_t wSel;
        regSel_t rSel;
        logic [31:0] dis;
        logic [33:0] rdWord;
        dis = 32'h0000_0000;
        rdWord = 34'h0_0000_0000;
        s_d = s_q;
        wSel = decode(s_q.awAddr);
        rSel = decode(axiReq.araddr);

        // Write address and data may arrive in either order
        if (axiReq.awvalid && s_q.awRdy) begin
            s_d.awFull = 1'b1;
            s_d.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && s_q.wRdy) begin
            s_d.wFull = 1'b1;
            s_d.wData = axiReq.wdata;
            s_d.wStrb = axiReq.wstrb;
        end
        if (s_q.bValid && axiReq.bready) begin
            s_d.bValid = 1'b0;
        end

        // Commit once both halves are held and the old response is gone
        if (s_q.awFull && s_q.wFull && !s_q.bValid) begin
            s_d.awFull = 1'b0;
            s_d.wFull = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp = writeResp(wSel);
            case (wSel)
                SEL_CORE_CFG: begin
                    // Only software reaches the core frequency setting
                    s_d.coreCfg = merge(s_q.coreCfg, s_q.wData, s_q.wStrb) & CFG_MASK;
                end
                SEL_BLK_DIS: begin
                    // Sticky: ones accumulate, zeros are ignored until reset
                    s_d.blkDis = s_q.blkDis
                        | (s_q.wData & strobeMask(s_q.wStrb) & BLK_MASK);
                end
                default: begin
                    // Read-only and unmapped targets change nothing
                end
            endcase
        end

        // Read channel
        if (s_q.rValid && axiReq.rready) begin
            s_d.rValid = 1'b0;
        end
        if (axiReq.arvalid && s_q.arRdy) begin
            rdWord = readMux(rSel, s_q.coreCfg, s_q.blkDis, s_q.blkEn, swBusy);
            s_d.rValid = 1'b1;
            s_d.rResp = rdWord[33:32];
            s_d.rData = rdWord[31:0];
        end

        // One write and one read outstanding at most
        s_d.awRdy = !s_d.awFull && !s_d.bValid;
        s_d.wRdy = !s_d.wFull && !s_d.bValid;
        s_d.arRdy = !s_d.rValid;

        // Demand gating: idle blocks stop, dispatch wakes them next cycle
        dis = s_d.blkDis;
        s_d.blkEn = ~dis[NBLK-1:0] & demand;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.coreCfg <= CORE_CFG_RESET;
            s_q.blkDis <= BLK_DIS_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-core glitchless source switch
    generate
        for (genvar c = 0; c < NCORE; c++) begin : g_core
            coreCfg_t req;
            assign req = coreReq(s_q.coreCfg, c);
            core_clk_switch u_sw (
                .mclk(mclk),
                .nrst(nrst),
                .pllLevel(pllLevel),
                .cfgReq(req),
                .coreClk(coreClkW[c]),
                .switching(swBusy[c]),
                .activeCfg()
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign axiRsp.awready = s_q.awRdy;
    assign axiRsp.wready = s_q.wRdy;
    assign axiRsp.bvalid = s_q.bValid;
    assign axiRsp.bresp = s_q.bResp;
    assign axiRsp.arready = s_q.arRdy;
    assign axiRsp.rvalid = s_q.rValid;
    assign axiRsp.rdata = s_q.rData;
    assign axiRsp.rresp = s_q.rResp;
    assign blockClkEn = s_q.blkEn;
    assign coreClk = coreClkW;
    assign coreSwitching = swBusy;

endmodule : clock_power_ctrl

//--- core/clk_ctrl_pkg.sv
package clk_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the AXI4-Lite port
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_CORE_CFG = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_CORE_STAT = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_BLK_DIS = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_BLK_EN = 12'h00C;

    ////////////////////////////////////////////////////////////////////////////
    // Per-core config nibble: [2] source, [1:0] divider, [3] reserved
    localparam int CFG_NIB_W = 4;
    localparam int CFG_USED_W = 3;
    localparam logic [3:0] CFG_NIB_MASK = 4'h7;
    localparam logic [31:0] CORE_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] BLK_DIS_RESET = 32'h0000_0000;
    localparam int MAX_CORES = 8;
    localparam int MAX_BLKS = 32;
    localparam int NUM_PLLS = 3;

    localparam logic [1:0] DIV_1 = 2'h0;
    localparam logic [1:0] DIV_2 = 2'h1;
    localparam logic [1:0] DIV_4 = 2'h2;
    localparam logic [1:0] DIV_8 = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic src;
        logic [1:0] div;
    } coreCfg_t;

    typedef enum logic [1:0] {SW_RUN, SW_STOP, SW_START} swState_t;

    typedef struct packed {
        swState_t st;
        coreCfg_t act;
        logic [2:0] cnt;
        logic srcPrev;
        logic clkOut;
        logic busy;
    } swReg_t;

    typedef enum logic [2:0] {
        SEL_CORE_CFG, SEL_CORE_STAT, SEL_BLK_DIS, SEL_BLK_EN, SEL_NONE
    } regSel_t;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axiReq_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axiRsp_t;

endpackage : clk_ctrl_pkg

//--- core/core_clk_switch.sv
`timescale 1ns/1ps
module core_clk_switch
    import clk_ctrl_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [NUM_PLLS-1:0] pllLevel,
    input wire coreCfg_t cfgReq,
    output logic coreClk,
    output logic switching,
    output coreCfg_t activeCfg
);

    swReg_t s_q;
    swReg_t s_d;

    // Direct taps on PLL0/PLL1, divided taps on PLL1/PLL2
    function automatic logic pickLevel(input coreCfg_t c, input logic [NUM_PLLS-1:0] p);
        logic r;
        if (c.div == DIV_1) begin
            r = c.src ? p[1] : p[0];
        end else begin
            r = c.src ? p[2] : p[1];
        end
        return r;
    endfunction : pickLevel

    function automatic logic wave(input logic [1:0] div, input logic lvl, input logic [2:0] cnt);
        logic r;
        case (div)
            DIV_1: r = lvl;
            DIV_2: r = cnt[0];
            DIV_4: r = cnt[1];
            default: r = cnt[2];
        endcase
        return r;
    endfunction : wave

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic lvl;
        lvl = pickLevel(s_q.act, pllLevel);
        s_d = s_q;
        s_d.srcPrev = lvl;
        if (lvl && !s_q.srcPrev) begin
            s_d.cnt = s_q.cnt + 3'h1;
        end
        case (s_q.st)
            SW_RUN: begin
                s_d.clkOut = wave(s_q.act.div, lvl, s_d.cnt);
                if (cfgReq != s_q.act) begin
                    s_d.st = SW_STOP;
                end
            end
            SW_STOP: begin
                // Let the old clock finish its high phase, freeze it low
                if (!s_q.clkOut) begin
                    s_d.clkOut = 1'b0;
                    s_d.act = cfgReq;
                    s_d.cnt = 3'h0;
                    s_d.srcPrev = 1'b1;
                    s_d.st = SW_START;
                end else begin
                    s_d.clkOut = wave(s_q.act.div, lvl, s_d.cnt);
                end
            end
            SW_START: begin
                // New source joins only while it is low: no runt pulse
                s_d.clkOut = 1'b0;
                s_d.cnt = 3'h0;
                if (!lvl) begin
                    s_d.st = SW_RUN;
                end
            end
            default: begin
                s_d.st = SW_RUN;
                s_d.clkOut = 1'b0;
            end
        endcase
        s_d.busy = (s_d.st != SW_RUN);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign coreClk = s_q.clkOut;
    assign switching = s_q.busy;
    assign activeCfg = s_q.act;

endmodule : core_clk_switch

//--- bench/clk_ctrl_properties.sv
`timescale 1ns/1ps
module clk_ctrl_properties
    import clk_ctrl_pkg::*;
#(
    parameter int NCORE = 4,
    parameter int NBLK = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire axiReq_t axiReq,
    input wire axiRsp_t axiRsp,
    input wire logic [NUM_PLLS-1:0] pllLevel,
    input wire logic [NBLK-1:0] workDispatch,
    input wire logic [NBLK-1:0] blockBusy,
    input wire logic [NBLK-1:0] blockClkEn,
    input wire logic [NCORE-1:0] coreClk,
    input wire logic [NCORE-1:0] coreSwitching
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    // Refusal with work pending can only mean disabled
    logic live_q;
    logic [NBLK-1:0] work_q;
    logic [NBLK-1:0] dead_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            live_q <= 1'b0;
            work_q <= '0;
            dead_q <= '0;
        end else begin
            live_q <= 1'b1;
            work_q <= workDispatch | blockBusy;
            dead_q <= dead_q | ({NBLK{live_q}} & work_q & ~blockClkEn);
        end
    end
    ////////////////////////////////////////
    sequence s_bGap;
        ##1 !axiRsp.bvalid ##1 axiRsp.bvalid;
    endsequence
    sequence s_settle;
        ##[1:400] !(|coreSwitching);
    endsequence
    property p_idleOff;
        live_q |-> (blockClkEn & ~work_q) == '0;
    endproperty
    a_idleOff: assert property (p_idleOff) else $error("enable without work");
    property p_stayOff;
        (dead_q & blockClkEn) == '0;
    endproperty
    a_stayOff: assert property (p_stayOff) else $error("disabled block on");
    property p_swCause;
        |(coreSwitching & ~$past(coreSwitching)) |->
            $past(axiRsp.bvalid) && !$past(axiRsp.bvalid, 2);
    endproperty
    a_swCause: assert property (p_swCause) else $error("switch without write");
    property p_lowStart;
        (coreSwitching & $past(coreSwitching) & coreClk & ~$past(coreClk)) == '0;
    endproperty
    a_lowStart: assert property (p_lowStart) else $error("clock rose in switch");
    property p_settle;
        $rose(|coreSwitching) |-> s_settle;
    endproperty
    a_settle: assert property (p_settle) else $error("switch too long");
    property p_bHold;
        axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp);
    endproperty
    a_bHold: assert property (p_bHold) else $error("bvalid dropped");
    property p_bTime;
        axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready |-> s_bGap;
    endproperty
    a_bTime: assert property (p_bTime) else $error("write answer late");
    property p_rHold;
        axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata);
    endproperty
    a_rHold: assert property (p_rHold) else $error("rvalid dropped");
    property p_rTime;
        axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid && !axiRsp.arready;
    endproperty
    a_rTime: assert property (p_rTime) else $error("read answer late");
endmodule : clk_ctrl_properties

//--- bench/clk_far_side.sv
`timescale 1ns/1ps
module clk_far_side
    import clk_ctrl_pkg::*;
#(
    parameter int NBLK = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [NBLK-1:0] workDispatch,
    output logic [NUM_PLLS-1:0] pllLevel,
    output logic [NBLK-1:0] blockBusy
);
    // Distinct half periods so every tap is told apart
    localparam int HALF [NUM_PLLS] = '{3, 4, 5};
    int pc_q [NUM_PLLS];
    logic [1:0] left_q [NBLK];
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pllLevel <= '0;
            pc_q <= '{default: 0};
            left_q <= '{default: 2'h0};
        end else begin
            for (int k = 0; k < NUM_PLLS; k++) begin
                pc_q[k] <= (pc_q[k] == HALF[k] - 1) ? 0 : pc_q[k] + 1;
                if (pc_q[k] == HALF[k] - 1) pllLevel[k] <= ~pllLevel[k];
            end
            // Work stays pending three cycles after dispatch
            for (int i = 0; i < NBLK; i++) begin
                if (workDispatch[i]) left_q[i] <= 2'h3;
                else if (left_q[i] != 2'h0) left_q[i] <= left_q[i] - 2'h1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < NBLK; i++) begin
            blockBusy[i] = left_q[i] != 2'h0;
        end
    end
endmodule : clk_far_side

//--- bench/test_clock_power_ctrl.sv
`timescale 1ns/1ps
module test_clock_power_ctrl
    import clk_ctrl_pkg::*;
;
    localparam int NCORE = 4;
    localparam int NBLK = 8;
    localparam int PER [8] = '{6, 8, 16, 20, 32, 40, 64, 80};
    logic mclk;
    logic nrst;
    axiReq_t req;
    axiRsp_t rsp;
    logic [NUM_PLLS-1:0] pll;
    logic [NBLK-1:0] wd;
    logic [NBLK-1:0] busy;
    logic [NBLK-1:0] en;
    logic [NCORE-1:0] cclk;
    logic [NCORE-1:0] csw;
    int errorCnt;
    int numChecks;
    int p;
    clock_power_ctrl #(.NCORE(NCORE), .NBLK(NBLK)) uut (
        .mclk(mclk), .nrst(nrst), .axiReq(req), .axiRsp(rsp), .pllLevel(pll),
        .workDispatch(wd), .blockBusy(busy), .blockClkEn(en), .coreClk(cclk),
        .coreSwitching(csw));
    clk_far_side #(.NBLK(NBLK)) far (.mclk(mclk), .nrst(nrst), .workDispatch(wd),
        .pllLevel(pll), .blockBusy(busy));
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic testDone();
        if (errorCnt == 0 && numChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : testDone
    // Ready raised only after a valid is seen, so stalls get exercised
    task automatic wc(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] e);
        logic ok;
        ok = 1'b0;
        @(posedge mclk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= s;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        repeat (100) begin
            @(posedge mclk);
            if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) begin
                ok = req.bready;
                if (req.bready) break;
                req.bready <= 1'b1;
            end
        end
        req.bready <= 1'b0;
        chk("bdone", 32'h0000_0001, {31'h0, ok});
        chk("bresp", {30'h0, e}, {30'h0, rsp.bresp});
    endtask : wc
    task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ok;
        ok = 1'b0;
        @(posedge mclk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        repeat (100) begin
            @(posedge mclk);
            if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) begin
                ok = req.rready;
                if (req.rready) break;
                req.rready <= 1'b1;
            end
        end
        req.rready <= 1'b0;
        chk("rdone", 32'h0000_0001, {31'h0, ok});
        chk("rdata", e, rsp.rdata);
        chk("rresp", {30'h0, er}, {30'h0, rsp.rresp});
    endtask : rc
    task automatic disp(input logic [NBLK-1:0] m, input logic [NBLK-1:0] e);
        @(posedge mclk);
        wd <= m;
        @(posedge mclk);
        wd <= '0;
        #1;
        chk("blockClkEn", {24'h0, e}, {24'h0, en});
        repeat (6) @(posedge mclk);
    endtask : disp
    task automatic per(output int n);
        int k;
        logic prv;
        k = 0;
        n = 0;
        prv = cclk[0];
        repeat (600) begin
            @(posedge mclk);
            #1;
            if (k >= 2) n++;
            if (cclk[0] && !prv) k++;
            prv = cclk[0];
            if (k == 3) break;
        end
    endtask : per
    ////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Whole run needs about 1000 cycles
    initial begin
        repeat (30000) @(posedge mclk);
        errorCnt++;
        testDone();
    end
    initial begin
        logic [3:0] nib;
        nrst = 1'b0;
        req = '0;
        wd = '0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        rc(OFF_CORE_CFG, CORE_CFG_RESET, RESP_OKAY);
        rc(OFF_BLK_DIS, BLK_DIS_RESET, RESP_OKAY);
        rc(12'h010, 32'h0000_0000, RESP_SLVERR);
        wc(12'h010, 32'h0000_0001, 4'hF, RESP_SLVERR);
        wc(OFF_CORE_STAT, 32'h0000_000F, 4'hF, RESP_OKAY);
        rc(OFF_CORE_STAT, 32'h0000_0000, RESP_OKAY);
        disp(8'h00, 8'h00);
        disp(8'h04, 8'h04);
        wc(OFF_BLK_DIS, 32'h0000_0004, 4'hF, RESP_OKAY);
        disp(8'h06, 8'h02);
        wc(OFF_BLK_DIS, 32'h0000_00FF, 4'h0, RESP_OKAY);
        wc(OFF_BLK_DIS, 32'h0000_0000, 4'hF, RESP_OKAY);
        rc(OFF_BLK_DIS, 32'h0000_0004, RESP_OKAY);
        disp(8'hFF, 8'hFB);
        rc(OFF_BLK_EN, 32'h0000_0000, RESP_OKAY);
        // Only a chip reset may bring a disabled block back
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        rc(OFF_BLK_DIS, BLK_DIS_RESET, RESP_OKAY);
        disp(8'h04, 8'h04);
        for (int i = 0; i < 8; i++) begin
            nib = {1'b0, i[0], i[2:1]};
            wc(OFF_CORE_CFG, {8{1'b1, nib[2:0]}}, 4'hF, RESP_OKAY);
            repeat (400) begin
                @(posedge mclk);
                #1;
                if (csw === '0) break;
            end
            chk("coreSwitching", 32'h0000_0000, {28'h0, csw});
            rc(OFF_CORE_CFG, {16'h0, {4{nib}}}, RESP_OKAY);
            per(p);
            chk("period", PER[i], p);
        end
        testDone();
    end
endmodule : test_clock_power_ctrl

bind clock_power_ctrl clk_ctrl_properties #(.NCORE(NCORE), .NBLK(NBLK)) props (
    .mclk(mclk), .nrst(nrst), .axiReq(axiReq), .axiRsp(axiRsp), .pllLevel(pllLevel),
    .workDispatch(workDispatch), .blockBusy(blockBusy), .blockClkEn(blockClkEn),
    .coreClk(coreClk), .coreSwitching(coreSwitching));
